// ---- t2co_top.sv ----
// Operation
// - Clock-out mode drives a 50% square wave
// - Output frequency is Fosc over 4*(65536-reload)
// - Overflow in clock-out mode reloads both bytes, or clears them when capture is selected
// - Clock-out overflows raise no interrupt request
// - Clock appears on shared count clock pin
// - Baud and clock-out share reload value
// - Overflow flag set unless serial clocking; software clears
// - External flag on trigger capture/reload; software clears
// - Bit 5 selects receive baud source
// - Bit 4 selects transmit baud source
// - Trigger edges act only if enabled, not in baud or up/down mode
// - Run bit stops or starts the counter
// - Bit 1 selects oscillator or pin edges
// - Serial clocking forces auto-reload, ignores capture select
// - Bit 0 selects reload or capture on trigger
// - Control register resets to zero
// - Mode bit 1 makes pin a clock output
// - Mode bit 0 enables up/down counting
// - Mode low bits reset zero; upper reserved
// - Up count overflow at FFFF reloads (clears in capture mode), sets flag
// - Down count at reload loads FFFF, sets flag
// - Up/down wrap toggles external flag, no interrupt
`timescale 1ns/100ps
`include "t2co_consts.svh"

module t2co_top #(
    parameter int AW = 12
) (
    input  wire logic          CLK,
    input  wire logic          NRST,
    input  wire logic [AW-1:0] ADR_I,
    input  wire logic [31:0]   DAT_I,
    output logic      [31:0]   DAT_O,
    input  wire logic          WE_I,
    input  wire logic [3:0]    SEL_I,
    input  wire logic          CYC_I,
    input  wire logic          STB_I,
    output logic               ACK_O,
    input  wire logic          CNT_PIN_I,
    output logic               CNT_PIN_O,
    output logic               CNT_PIN_OE_N,
    input  wire logic          TRIG_PIN_I,
    input  wire logic          TIMER1_OVF,
    output logic               RX_BAUD_TICK,
    output logic               TX_BAUD_TICK,
    output logic               IRQ_REQ
);

    // ==========================================================
    // State
    logic [5:0]         ctl;
    logic               overflow_flag;
    logic               external_flag;
    logic [1:0]         mode;
    t2co_pkg::t2co_word_t count;
    t2co_pkg::t2co_word_t reload;
    logic [3:0]         presc;
    logic [2:0]         cnt_sync;
    logic [2:0]         trig_sync;

    wire logic tx_clock_select         = ctl[`T2CO_CTL_TXSEL];
    wire logic rx_clock_select         = ctl[`T2CO_CTL_RXSEL];
    wire logic external_trigger_enable = ctl[`T2CO_CTL_TRIGEN];
    wire logic run_control             = ctl[`T2CO_CTL_RUN];
    wire logic counter_timer_select    = ctl[`T2CO_CTL_CTSEL];
    wire logic capture_reload_select   = ctl[`T2CO_CTL_CPSEL];
    wire logic clock_out_enable        = mode[`T2CO_MOD_CLKOE];
    wire logic updown_enable           = mode[`T2CO_MOD_UPDOWN];
    wire logic baud_mode               = rx_clock_select | tx_clock_select;

    // ==========================================================
    // Bus decode
    logic [9:0] idx;
    logic       bus_wr;
    logic       wr_ctl;
    logic       wr_mod;
    logic       wr_clo;
    logic       wr_chi;
    logic       wr_rlo;
    logic       wr_rhi;
    logic [7:0] wd;

    assign idx    = ADR_I[11:2];
    assign wd     = DAT_I[7:0];
    assign bus_wr = CYC_I & STB_I & ACK_O & WE_I & SEL_I[0];
    assign wr_ctl = bus_wr & (idx == `T2CO_IDX_CTRL);
    assign wr_mod = bus_wr & (idx == `T2CO_IDX_MODE);
    assign wr_clo = bus_wr & (idx == `T2CO_IDX_CNT_LO);
    assign wr_chi = bus_wr & (idx == `T2CO_IDX_CNT_HI);
    assign wr_rlo = bus_wr & (idx == `T2CO_IDX_RLD_LO);
    assign wr_rhi = bus_wr & (idx == `T2CO_IDX_RLD_HI);

    // ==========================================================
    // Pin synchronisers and edge detect
    logic cnt_fall;
    logic trig_fall;
    logic trig_lvl;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cnt_sync  <= 3'h7;
            trig_sync <= 3'h7;
        end else begin
            cnt_sync  <= {cnt_sync[1:0], CNT_PIN_I};
            trig_sync <= {trig_sync[1:0], TRIG_PIN_I};
        end
    end

    assign cnt_fall  = cnt_sync[2] & ~cnt_sync[1];
    assign trig_fall = trig_sync[2] & ~trig_sync[1];
    assign trig_lvl  = trig_sync[1];

    // ==========================================================
    // Count input selection
    logic [3:0] div;
    logic       tick;

    assign div = (clock_out_enable | baud_mode) ? `T2CO_FAST_DIV : `T2CO_TIMER_DIV;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            presc <= 4'h0;
        end else if (!run_control || presc >= div - 4'h1) begin
            presc <= 4'h0;
        end else begin
            presc <= presc + 4'h1;
        end
    end

    assign tick = run_control & (counter_timer_select ? cnt_fall : (presc >= div - 4'h1));

    // ==========================================================
    // Counter engine
    t2co_pkg::t2co_mode_t op_mode;
    t2co_pkg::t2co_word_t next_count;
    t2co_pkg::t2co_word_t next_reload;
    logic                 ovf;
    logic                 unf;
    logic                 ext_set;

    always_comb begin
        if (baud_mode) begin
            op_mode = t2co_pkg::T2CO_MODE_BAUD;
        end else if (capture_reload_select) begin
            op_mode = t2co_pkg::T2CO_MODE_CAPTURE;
        end else if (updown_enable) begin
            op_mode = t2co_pkg::T2CO_MODE_UPDOWN;
        end else begin
            op_mode = t2co_pkg::T2CO_MODE_RELOAD;
        end
    end

    always_comb begin
        next_count  = count;
        next_reload = reload;
        ovf         = 1'b0;
        unf         = 1'b0;
        ext_set     = 1'b0;
        if (tick) begin
            if (op_mode == t2co_pkg::T2CO_MODE_UPDOWN && !trig_lvl) begin
                if (count == reload) begin
                    next_count = `T2CO_CNT_TOP;
                    unf        = 1'b1;
                end else begin
                    next_count = count - 16'h0001;
                end
            end else if (count == `T2CO_CNT_TOP) begin
                ovf = 1'b1;
                next_count = (op_mode == t2co_pkg::T2CO_MODE_CAPTURE) ? 16'h0000 : reload;
            end else begin
                next_count = count + 16'h0001;
            end
        end
        if (trig_fall && external_trigger_enable) begin
            unique case (op_mode)
                t2co_pkg::T2CO_MODE_CAPTURE: begin
                    next_reload = count;
                    ext_set     = 1'b1;
                end
                t2co_pkg::T2CO_MODE_RELOAD: begin
                    next_count = reload;
                    ext_set    = 1'b1;
                end
                t2co_pkg::T2CO_MODE_UPDOWN,
                t2co_pkg::T2CO_MODE_BAUD: begin
                    ext_set = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            count <= 16'h0000;
        end else begin
            count[7:0]  <= wr_clo ? wd : next_count[7:0];
            count[15:8] <= wr_chi ? wd : next_count[15:8];
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            reload <= 16'h0000;
        end else begin
            reload[7:0]  <= wr_rlo ? wd : next_reload[7:0];
            reload[15:8] <= wr_rhi ? wd : next_reload[15:8];
        end
    end

    // ==========================================================
    // Control and mode registers, flags
    logic ext_base;

    assign ext_base = wr_ctl ? wd[`T2CO_CTL_EXT] : external_flag;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctl <= 6'(`T2CO_CTL_RESET);
        end else if (wr_ctl) begin
            ctl <= wd[5:0];
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mode <= `T2CO_MOD_RESET;
        end else if (wr_mod) begin
            mode <= wd[1:0];
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            overflow_flag <= 1'b0;
        end else begin
            overflow_flag <= ((ovf | unf) & ~baud_mode) |
                             (wr_ctl ? wd[`T2CO_CTL_OVF] : overflow_flag);
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            external_flag <= 1'b0;
        end else if (op_mode == t2co_pkg::T2CO_MODE_UPDOWN) begin
            external_flag <= ext_base ^ (ovf | unf);
        end else begin
            external_flag <= ext_set | ext_base;
        end
    end

    // ==========================================================
    // Outputs
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            IRQ_REQ <= 1'b0;
        end else begin
            IRQ_REQ <= (overflow_flag & ~clock_out_enable) | (external_flag & ~updown_enable);
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            CNT_PIN_O    <= 1'b1;
            CNT_PIN_OE_N <= 1'b1;
        end else begin
            CNT_PIN_OE_N <= ~clock_out_enable;
            if (clock_out_enable && ovf) begin
                CNT_PIN_O <= ~CNT_PIN_O;
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            RX_BAUD_TICK <= 1'b0;
            TX_BAUD_TICK <= 1'b0;
        end else begin
            RX_BAUD_TICK <= rx_clock_select ? ovf : TIMER1_OVF;
            TX_BAUD_TICK <= tx_clock_select ? ovf : TIMER1_OVF;
        end
    end

    // ==========================================================
    // Wishbone slave
    logic [7:0] rd;

    always_comb begin
        unique case (idx)
            `T2CO_IDX_CTRL:   rd = {overflow_flag, external_flag, ctl};
            `T2CO_IDX_MODE:   rd = {6'h00, mode};
            `T2CO_IDX_CNT_LO: rd = count[7:0];
            `T2CO_IDX_CNT_HI: rd = count[15:8];
            `T2CO_IDX_RLD_LO: rd = reload[7:0];
            `T2CO_IDX_RLD_HI: rd = reload[15:8];
            default:          rd = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h00000000;
        end else begin
            ACK_O <= CYC_I & STB_I & ~ACK_O;
            if (CYC_I && STB_I && !ACK_O) begin
                DAT_O <= {24'h000000, rd};
            end
        end
    end

    // ==========================================================
    // Checks
    sequence s_co_wrap;
        clock_out_enable && !baud_mode && tick && count == 16'hFFFF && !wr_clo && !wr_chi;
    endsequence

    sequence s_down_hit;
        op_mode == t2co_pkg::T2CO_MODE_UPDOWN && tick && !trig_lvl && count == reload
            && !wr_clo && !wr_chi;
    endsequence

    clkout_reload_a: assert property (@(posedge CLK) disable iff (!NRST)
        s_co_wrap and !(trig_fall && external_trigger_enable) |=> count == $past(reload))
        else $error("clock-out overflow did not reload");

    pin_toggle_a: assert property (@(posedge CLK) disable iff (!NRST)
        s_co_wrap |=> CNT_PIN_O != $past(CNT_PIN_O))
        else $error("clock-out pin did not toggle");

    down_reload_a: assert property (@(posedge CLK) disable iff (!NRST)
        s_down_hit |=> count == 16'hFFFF && overflow_flag)
        else $error("down count at reload not handled");

    flag_baud_a: assert property (@(posedge CLK) disable iff (!NRST)
        baud_mode && !overflow_flag && !wr_ctl |=> !overflow_flag)
        else $error("overflow flag set while clocking serial port");

    flag_set_a: assert property (@(posedge CLK) disable iff (!NRST)
        ovf && !baud_mode |=> overflow_flag)
        else $error("overflow flag not set");

    stopped_count_a: assert property (@(posedge CLK) disable iff (!NRST)
        !run_control && !wr_clo && !wr_chi && !(trig_fall && external_trigger_enable)
        |=> count == $past(count))
        else $error("counter moved while stopped");

    trig_ignore_a: assert property (@(posedge CLK) disable iff (!NRST)
        !external_trigger_enable && !updown_enable && !external_flag && !wr_ctl
        |=> !external_flag)
        else $error("external flag set with trigger disabled");

    clkout_irq_a: assert property (@(posedge CLK) disable iff (!NRST)
        clock_out_enable && !external_flag
        |=> !IRQ_REQ)
        else $error("interrupt raised in clock-out mode");

    updown_toggle_a: assert property (@(posedge CLK) disable iff (!NRST)
        op_mode == t2co_pkg::T2CO_MODE_UPDOWN && (ovf || unf) && !wr_ctl
        |=> external_flag != $past(external_flag))
        else $error("external flag did not toggle on wrap");

    pin_enable_a: assert property (@(posedge CLK) disable iff (!NRST)
        wr_mod ##1 1'b1 |=> CNT_PIN_OE_N == !$past(wd[1], 2))
        else $error("pin enable does not follow mode bit");

endmodule // t2co_top

// ---- t2co_consts.svh ----
`ifndef T2CO_CONSTS_SVH
`define T2CO_CONSTS_SVH

// ==========================================================
// Register indices (byte address = index * 4)
`define T2CO_IDX_CTRL      10'h0C8
`define T2CO_IDX_MODE      10'h0C9
`define T2CO_IDX_CNT_LO    10'h0D0
`define T2CO_IDX_CNT_HI    10'h0D1
`define T2CO_IDX_RLD_LO    10'h0D2
`define T2CO_IDX_RLD_HI    10'h0D3

// ==========================================================
// Control register fields
`define T2CO_CTL_OVF       7
`define T2CO_CTL_EXT       6
`define T2CO_CTL_RXSEL     5
`define T2CO_CTL_TXSEL     4
`define T2CO_CTL_TRIGEN    3
`define T2CO_CTL_RUN       2
`define T2CO_CTL_CTSEL     1
`define T2CO_CTL_CPSEL     0

// ==========================================================
// Mode register fields
`define T2CO_MOD_CLKOE     1
`define T2CO_MOD_UPDOWN    0

// ==========================================================
// Reset values and counts
`define T2CO_CTL_RESET     8'h00
`define T2CO_MOD_RESET     2'h0
`define T2CO_CNT_TOP       16'hFFFF
`define T2CO_TIMER_DIV     4'hC
`define T2CO_FAST_DIV      4'h2

`endif

// ---- t2co_pkg.sv ----
package t2co_pkg;

    typedef logic [15:0] t2co_word_t;

    typedef enum logic [1:0] {
        T2CO_MODE_CAPTURE,
        T2CO_MODE_RELOAD,
        T2CO_MODE_UPDOWN,
        T2CO_MODE_BAUD
    } t2co_mode_t;

endpackage

// ---- t2co_pins.sv ----
`timescale 1ns/100ps
// ==========
// Pin-side event source
module t2co_pins (
    input  wire logic CLK,
    input  wire logic pin_o,
    input  wire logic oe_n,
    output logic      cnt_pin,
    output logic      trig_pin
);
    logic drv = 1'b1;

    // Bench drive level (high when idle, low during pulses) whenever the timer releases the pin
    assign cnt_pin = oe_n ? drv : pin_o;

    initial trig_pin = 1'b1;

    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge CLK) drv <= 1'b0;
            repeat (4) @(posedge CLK);
            drv <= 1'b1;
            repeat (4) @(posedge CLK);
        end
    endtask

    task automatic trig(input logic lvl);
        @(posedge CLK) trig_pin <= lvl;
        repeat (6) @(posedge CLK);
    endtask
endmodule // t2co_pins

// ---- t2co_top_tb.sv ----
`timescale 1ns/100ps
`include "t2co_consts.svh"
module t2co_top_tb;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [3:0]  wsel = 4'h1;
    logic        t1ovf = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] dw = 32'h0;
    logic [31:0] dr;
    logic        ack, pin_i, pin_o, oe_n, trig, rxt, txt, irq;
    logic [7:0]  r, q;
    int          error_cnt = 0;
    int          cmp_count = 0;

    always #50 clk = ~clk;

    t2co_top dut (
        .CLK(clk), .NRST(nrst), .ADR_I(adr), .DAT_I(dw), .DAT_O(dr),
        .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
        .CNT_PIN_I(pin_i), .CNT_PIN_O(pin_o), .CNT_PIN_OE_N(oe_n),
        .TRIG_PIN_I(trig), .TIMER1_OVF(t1ovf), .RX_BAUD_TICK(rxt),
        .TX_BAUD_TICK(txt), .IRQ_REQ(irq)
    );

    t2co_pins pins (
        .CLK(clk), .pin_o(pin_o), .oe_n(oe_n), .cnt_pin(pin_i), .trig_pin(trig)
    );

    // ==========
    // Bench tasks
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic [9:0] idx, input logic w, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= {idx, idx[1:0]};
        dw <= {~d, d, ~d, d};
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        r = dr[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 20) begin
            error_cnt++;
            test_done();
        end
    endtask

    task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
        wb(idx, 1'b0, 8'h00);
        chk({8'h00, r}, {8'h00, e});
    endtask

    // Cycles between two events: pin toggle, tx tick or rx tick
    task automatic gap(input int k, input int e);
        logic p, c;
        int m;
        p = pin_o;
        m = 0;
        for (int j = 0; j < 2; j++) begin
            m = 0;
            do begin
                @(posedge clk);
                m++;
                c = (k == 0) ? (pin_o !== p) : (k == 1) ? txt : rxt;
                p = pin_o;
            end while (c !== 1'b1 && m < 3000);
        end
        if (m >= 3000) begin
            error_cnt++;
            test_done();
        end
        chk(m[15:0], e[15:0]);
    endtask

    // ==========
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rdc(`T2CO_IDX_CTRL, 8'h00);
        rdc(`T2CO_IDX_MODE, 8'h00);
        chk({15'h0, oe_n}, 16'h0001);
        rdc(10'h0C0, 8'h00);
        wsel = 4'hE;
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h08);
        wsel = 4'h1;
        rdc(`T2CO_IDX_CTRL, 8'h00);
        $display("Test registers done");
        t1ovf <= 1'b1;
        @(posedge clk);
        t1ovf <= 1'b0;
        @(posedge clk);
        chk({14'h0, rxt, txt}, 16'h0003);
        @(posedge clk);
        chk({14'h0, rxt, txt}, 16'h0000);
        $display("Test timer 1 ticks done");

        wb(`T2CO_IDX_MODE, 1'b1, 8'h02);
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h30);
        wb(`T2CO_IDX_RLD_LO, 1'b1, 8'h00);
        wb(`T2CO_IDX_RLD_HI, 1'b1, 8'hFE);
        wb(`T2CO_IDX_CNT_LO, 1'b1, 8'hF0);
        wb(`T2CO_IDX_CNT_HI, 1'b1, 8'hFF);
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h34);
        chk({15'h0, oe_n}, 16'h0000);
        gap(0, 1024);
        rdc(`T2CO_IDX_CNT_HI, 8'hFE);
        gap(1, 1024);
        gap(2, 1024);
        rdc(`T2CO_IDX_CTRL, 8'h34);
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h04);
        gap(0, 1024);
        rdc(`T2CO_IDX_CTRL, 8'h84);
        chk({15'h0, irq}, 16'h0000);
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h00);
        wb(`T2CO_IDX_MODE, 1'b1, 8'h00);
        repeat (2) @(posedge clk);
        chk({15'h0, oe_n}, 16'h0001);
        $display("Test clock-out done");

        wb(`T2CO_IDX_CNT_LO, 1'b1, 8'hFF);
        wb(`T2CO_IDX_CNT_HI, 1'b1, 8'hFF);
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h04);
        repeat (30) @(posedge clk);
        rdc(`T2CO_IDX_CTRL, 8'h84);
        chk({15'h0, irq}, 16'h0001);
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h00);
        rdc(`T2CO_IDX_CNT_HI, 8'hFE);
        wb(`T2CO_IDX_CNT_LO, 1'b0, 8'h00);
        q = r;
        repeat (40) @(posedge clk);
        rdc(`T2CO_IDX_CNT_LO, q);
        chk({15'h0, irq}, 16'h0000);
        $display("Test timer done");

        wb(`T2CO_IDX_CNT_LO, 1'b1, 8'h00);
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h06);
        pins.pulses(5);
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h00);
        rdc(`T2CO_IDX_CNT_LO, 8'h05);
        $display("Test counter done");

        wb(`T2CO_IDX_CNT_LO, 1'b1, 8'h34);
        wb(`T2CO_IDX_CNT_HI, 1'b1, 8'h12);
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h01);
        pins.trig(1'b0);
        pins.trig(1'b1);
        rdc(`T2CO_IDX_RLD_HI, 8'hFE);
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h09);
        pins.trig(1'b0);
        rdc(`T2CO_IDX_RLD_HI, 8'h12);
        rdc(`T2CO_IDX_CTRL, 8'h49);
        chk({15'h0, irq}, 16'h0001);
        pins.trig(1'b1);
        wb(`T2CO_IDX_CNT_HI, 1'b1, 8'h00);
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h08);
        pins.trig(1'b0);
        rdc(`T2CO_IDX_CNT_HI, 8'h12);
        rdc(`T2CO_IDX_CTRL, 8'h48);
        pins.trig(1'b1);
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h18);
        pins.trig(1'b0);
        rdc(`T2CO_IDX_CTRL, 8'h18);
        $display("Test trigger done");

        wb(`T2CO_IDX_MODE, 1'b1, 8'h01);
        wb(`T2CO_IDX_RLD_LO, 1'b1, 8'h10);
        wb(`T2CO_IDX_RLD_HI, 1'b1, 8'h00);
        wb(`T2CO_IDX_CNT_LO, 1'b1, 8'h11);
        wb(`T2CO_IDX_CNT_HI, 1'b1, 8'h00);
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h04);
        repeat (40) @(posedge clk);
        rdc(`T2CO_IDX_CTRL, 8'hC4);
        rdc(`T2CO_IDX_CNT_HI, 8'hFF);
        wb(`T2CO_IDX_CTRL, 1'b1, 8'h44);
        repeat (2) @(posedge clk);
        chk({15'h0, irq}, 16'h0000);
        pins.trig(1'b1);
        repeat (100) @(posedge clk);
        rdc(`T2CO_IDX_CTRL, 8'h84);
        rdc(`T2CO_IDX_CNT_HI, 8'h00);
        $display("Test up/down done");
        test_done();
    end
endmodule // t2co_top_tb
